// file: design/rvm_defs.svh
// Register offsets, field positions, reset values and scaling constants.
`ifndef RVM_DEFS_SVH
`define RVM_DEFS_SVH

`define RVM_OFS_VOUT_HIGH     8'h05
`define RVM_OFS_IRQ_MASK      8'h06
`define RVM_OFS_IRQ_STATUS    8'h07

`define RVM_VOUT_HIGH_RST     7'h38
`define RVM_IRQ_MASK_RST      4'h0
`define RVM_STATUS_RST        4'h0

`define RVM_BIT_THERMAL       3
`define RVM_BIT_POWER_GOOD    2
`define RVM_BIT_OVERVOLTAGE   1
`define RVM_BIT_OVERCURRENT   0

`define RVM_GPIO_CFG_VSEL     3'h3
`define RVM_VOUT_BASE_MV      13'h0a28
`define RVM_VOUT_STEP_MV      13'h0014

`endif

// file: design/rvm_pkg.sv
// Types shared by the regulator register bank modules.
package rvm_pkg;

   typedef struct packed {
      logic       primed;
      logic [3:0] prev;
      logic [3:0] flags;
   } rvm_latch_state_type;

   typedef struct packed {
      logic [6:0]  vout_high;
      logic [3:0]  mask;
      logic [7:0]  rdata;
      logic        irq;
      logic        vsel_active;
      logic [12:0] target_mv;
   } rvm_bank_state_type;

endpackage

// file: design/rvm_event_latch.sv
// Sticky event flags with edge detection and clear-on-read.
`timescale 1ns/10ps
`include "rvm_defs.svh"

module rvm_event_latch
   import rvm_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Sources, each already turned so that a rising edge is the event.
   input  wire logic [3:0] src_rise,
   // Clear pulse from a status read.
   input  wire logic       clear,
   // Sticky flags.
   output logic      [3:0] flags
);

   rvm_latch_state_type state_reg;
   rvm_latch_state_type state_next;

   always_comb begin
      state_next        = state_reg;
      state_next.prev   = src_rise;
      state_next.primed = 1'b1;
      // The first cycle after reset only samples, so a source that is
      // already active at release does not fake an edge.
      if (clear) begin
         state_next.flags = 4'h0;
      end
      if (state_reg.primed) begin
         // Set wins over a clear in the same cycle.
         state_next.flags = state_next.flags
                          | (src_rise & ~state_reg.prev);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg.primed <= 1'b0;
         state_reg.prev   <= 4'h0;
         state_reg.flags  <= `RVM_STATUS_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flags = state_reg.flags;

endmodule

// file: design/rvm_regs.sv
// Alternate output-voltage and interrupt mask/status register bank.
`timescale 1ns/10ps
`include "rvm_defs.svh"

module rvm_regs
   import rvm_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Register access port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Regulator condition inputs.
   input  wire logic        thermal_shutdown_state,
   input  wire logic        regulator_power_good_n,
   input  wire logic        regulator_overvoltage_state,
   input  wire logic        regulator_overcurrent_state,
   // Multifunction pin.
   input  wire logic [2:0]  gpio_cfg,
   input  wire logic        gpio_level,
   // Results.
   output logic      [6:0]  output_voltage_high_sel,
   output logic             vout_high_active,
   output logic      [12:0] vout_high_target_mv,
   output logic             irq_active
);

   ////////////////////////////////////////////////////////////////////////

   rvm_bank_state_type state_reg;
   rvm_bank_state_type state_next;
   logic [3:0]         src_rise;
   logic [3:0]         status;
   logic               status_read;

   // Linear code to millivolts. The product of the code and the step stays
   // well inside 13 bits, so the sized cast drops no meaningful bit.
   function automatic logic [12:0] code_to_mv(input logic [6:0] code);
      logic [12:0] steps;
      steps = {6'h00, code};
      code_to_mv = 13'(`RVM_VOUT_BASE_MV + steps * `RVM_VOUT_STEP_MV);
   endfunction

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      src_rise = 4'h0;
      src_rise[`RVM_BIT_THERMAL]     = thermal_shutdown_state;
      // Power-good is flagged on the falling edge of its low-true input.
      src_rise[`RVM_BIT_POWER_GOOD]  = ~regulator_power_good_n;
      src_rise[`RVM_BIT_OVERVOLTAGE] = regulator_overvoltage_state;
      src_rise[`RVM_BIT_OVERCURRENT] = regulator_overcurrent_state;
   end

   assign status_read = reg_rd && (reg_addr == `RVM_OFS_IRQ_STATUS);

   rvm_event_latch u_event_latch (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .src_rise (src_rise),
      .clear    (status_read),
      .flags    (status)
   );

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      state_next = state_reg;
      if (reg_wr) begin
         case (reg_addr)
            `RVM_OFS_VOUT_HIGH: begin
               state_next.vout_high = reg_wdata[6:0];
            end
            `RVM_OFS_IRQ_MASK: begin
               state_next.mask = reg_wdata[3:0];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `RVM_OFS_VOUT_HIGH: begin
               state_next.rdata = {1'b0, state_reg.vout_high};
            end
            `RVM_OFS_IRQ_MASK: begin
               state_next.rdata = {4'h0, state_reg.mask};
            end
            `RVM_OFS_IRQ_STATUS: begin
               state_next.rdata = {4'h0, status};
            end
            default: begin
               state_next.rdata = 8'h00;
            end
         endcase
      end
      // Indication follows the flags by one cycle; a masked flag stays
      // pending and raises it as soon as its mask bit is cleared.
      state_next.irq = |(status & ~state_reg.mask);
      state_next.vsel_active = (gpio_cfg == `RVM_GPIO_CFG_VSEL)
                             && gpio_level;
      state_next.target_mv = code_to_mv(state_reg.vout_high);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg.vout_high   <= `RVM_VOUT_HIGH_RST;
         state_reg.mask        <= `RVM_IRQ_MASK_RST;
         state_reg.rdata       <= 8'h00;
         state_reg.irq         <= 1'b0;
         state_reg.vsel_active <= 1'b0;
         state_reg.target_mv   <= 13'h0000;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata               = state_reg.rdata;
   assign output_voltage_high_sel = state_reg.vout_high;
   assign vout_high_active        = state_reg.vsel_active;
   assign vout_high_target_mv     = state_reg.target_mv;
   assign irq_active              = state_reg.irq;

endmodule

// file: verification/rvm_host_model.sv
// Host model that drives the register port.
`timescale 1ns/10ps
module rvm_host_model (
   // Register port.
   input logic        clock,
   output logic [7:0] reg_addr = 8'h00,
   output logic       reg_wr = 0,
   output logic [7:0] reg_wdata = 8'h00,
   output logic       reg_rd = 0,
   input logic [7:0]  reg_rdata
);
   // Released address and data are inverted and the strobes dropped, so a stale byte never looks valid.
   task automatic xfer(logic w, logic [7:0] a, d, output logic [7:0] q);
      @(posedge clock) #1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
      @(posedge clock) #1;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
      q = reg_rdata;
   endtask
endmodule

// file: verification/rvm_regs_chk.sv
// Port assertions for the register bank.
`timescale 1ns/10ps
module rvm_regs_chk (
   // Watched ports.
   input logic        clock,
   input logic        sys_rst,
   input logic [7:0]  reg_addr,
   input logic        reg_wr,
   input logic [7:0]  reg_wdata,
   input logic        reg_rd,
   input logic [7:0]  reg_rdata,
   input logic [2:0]  gpio_cfg,
   input logic        gpio_level,
   input logic [6:0]  output_voltage_high_sel,
   input logic        vout_high_active,
   input logic [12:0] vout_high_target_mv,
   input logic        irq_active
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_rd(a); reg_rd && reg_addr == a; endsequence
   sequence s_wr(a); reg_wr && reg_addr == a; endsequence
   chk_code_reset: assert property (disable iff (1'b0)
      sys_rst |=> output_voltage_high_sel == 7'h38) else $error("code rst");
   chk_code_write: assert property (s_wr(8'h05) |=>
      output_voltage_high_sel == $past(reg_wdata[6:0])) else $error("code");
   chk_code_hold: assert property (
      !(reg_wr && reg_addr == 8'h05) |=> $stable(output_voltage_high_sel))
      else $error("code moved");
   // Outputs lag one edge, so the edge right after reset is skipped.
   chk_target_scale: assert property (!$past(sys_rst) |->
      vout_high_target_mv == 13'h0a28 + 13'h0014 * $past(
      output_voltage_high_sel)) else $error("target");
   chk_vsel_decode: assert property (!$past(sys_rst) |->
      vout_high_active == ($past(gpio_cfg) == 3'h3 && $past(gpio_level)))
      else $error("vsel");
   chk_mask_upper: assert property (s_rd(8'h06) |=>
      reg_rdata[7:4] == 4'h0) else $error("mask upper");
   chk_status_upper: assert property (s_rd(8'h07) |=>
      reg_rdata[7:4] == 4'h0) else $error("status upper");
   chk_irq_fall: assert property ($fell(irq_active) |->
      $past(sys_rst) || $past(reg_rd, 2) || $past(reg_wr, 2))
      else $error("irq fall");
endmodule
bind rvm_regs rvm_regs_chk chk (.*);

// file: verification/tb_top.sv
// Self-checking bench for the register bank.
`timescale 1ns/10ps
module tb_top;
   logic        clock = 0;
   logic        sys_rst = 1;
   logic [3:0]  src = 4'h0;
   logic [2:0]  gpio_cfg = 3'h3;
   logic        gpio_level = 1;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
   logic        reg_wr, reg_rd, vout_high_active, irq_active;
   logic [6:0]  output_voltage_high_sel;
   logic [12:0] vout_high_target_mv;
   wire         thermal_shutdown_state = src[3];
   wire         regulator_power_good_n = !src[2];
   wire         regulator_overvoltage_state = src[1];
   wire         regulator_overcurrent_state = src[0];
   int          err_total = 0;
   int          comparisons = 0;
   always #20 clock = ~clock;
   rvm_host_model host (.*);
   rvm_regs dut (.*);
   ///////////////////////////////////////////////////////////////////
   task automatic check(logic [12:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(logic [7:0] a, exp);
      host.xfer(0, a, 8'h00, q);
      check(q, exp);
   endtask
   task automatic print_verdict;
      $display("compares %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #20000 err_total++;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge clock);
      #1 sys_rst = 0;
      rd(8'h05, 8'h38);
      rd(8'h06, 8'h00);
      check(vout_high_target_mv, 13'h0e88);
      check(vout_high_active, 1);
      host.xfer(1, 8'h05, 8'hff, q);
      rd(8'h05, 8'h7f);
      check(vout_high_target_mv, 13'h1414);
      host.xfer(1, 8'h05, 8'h0d, q);
      gpio_level = 0;
      rd(8'h05, 8'h0d);
      check(vout_high_target_mv, 13'h0b2c);
      check(vout_high_active, 0);
      gpio_cfg = 3'h2;
      gpio_level = 1;
      host.xfer(1, 8'h06, 8'hff, q);
      rd(8'h06, 8'h0f);
      host.xfer(1, 8'h07, 8'hff, q);
      rd(8'h07, 8'h00);
      check(vout_high_active, 0);
      for (int i = 0; i < 4; i++) begin
         host.xfer(1, 8'h06, 8'h01 << i, q);
         src[i] = 1;
         repeat (4) @(posedge clock);
         #1 check(irq_active, 0);
         host.xfer(1, 8'h06, 8'h00, q);
         repeat (2) @(posedge clock);
         #1 check(irq_active, 1);
         src[i] = 0;
         rd(8'h07, 8'h01 << i);
      end
      print_verdict;
   end
endmodule
